// ### hdl/ord_decode.sv
`timescale 1ns/1ns
`include "ord_map.svh"

module ord_decode (
	input  wire logic        CLOCK_I,
	input  wire logic        RST_I,
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	input  wire logic        WE_I,
	input  wire logic [7:0]  ADR_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic [31:0] DAT_I,
	output logic      [31:0] DAT_O,
	output logic             ACK_O,
	output logic      [1:0]  OPSIZE_O,
	output logic             ADDR32_O,
	output logic             SIB_PRESENT_O,
	output logic      [2:0]  SEG_SEL_O,
	output logic             SEG_BAD_O
);

	////////////////////////////////////////////////////////////////
	// bus side state

	logic [`ORD_CTRL_W-1:0] ctrl_reg;    // software control
	logic [31:0]            insn_reg;    // opcode, mod/rm, sib, w
	logic                   ack_reg;     // bus answer
	logic [31:0]            dat_reg;     // read data
	logic [31:0]            rd_next;     // read mux
	logic                   req;         // new bus request

	////////////////////////////////////////////////////////////////
	// decode results, all registered

	ord_pkg::ord_size_e size_reg;        // operand width
	ord_pkg::ord_seg_e  seg_reg;         // segment picked
	logic               ad32_reg;        // 32-bit addressing
	logic [2:0]         gpr_reg;         // register index
	logic               bytereg_reg;     // byte register
	logic               high_reg;        // high byte half
	logic               seg_bad_reg;     // unused seg code
	logic               sib_reg;         // sib follows
	logic [1:0]         disp_reg;        // displacement size
	logic               stack_reg;       // stack seg default
	logic               regmode_reg;     // operand is register
	logic               implied_reg;     // fixed mode
	logic [2:0]         ext_reg;         // opcode extension
	logic [1:0]         scale_reg;       // sib scale
	logic [2:0]         index_reg;       // sib index
	logic [2:0]         base_reg;        // sib base
	logic               noidx_reg;       // no index used

	////////////////////////////////////////////////////////////////
	// next values

	ord_pkg::ord_size_e size_next;
	ord_pkg::ord_seg_e  seg_next;
	logic               op32;            // effective operand size
	logic               ad32;            // effective address size
	logic               d_eff;           // default after mode
	logic [2:0]         code;            // chosen register code
	logic [2:0]         gpr_next;
	logic               bytereg_next;
	logic               high_next;
	logic               seg_bad_next;
	logic               sib_next;
	logic [1:0]         disp_next;
	logic               stack_next;
	logic               regmode_next;
	logic [2:0]         ext_next;

	// instruction fields
	logic [7:0] opc;
	logic [1:0] mdf;
	logic [2:0] mid;
	logic [2:0] rmf;
	logic [1:0] ssf;
	logic [2:0] idxf;
	logic [2:0] basf;
	logic       wbit;
	logic       wpres;
	logic       impl;

	assign opc   = insn_reg[7:0];
	assign mdf   = insn_reg[15:14];
	assign mid   = insn_reg[13:11];
	assign rmf   = insn_reg[10:8];
	assign ssf   = insn_reg[23:22];      // two bits
	assign idxf  = insn_reg[21:19];      // three bits
	assign basf  = insn_reg[18:16];
	assign wbit  = insn_reg[`ORD_I_WBIT];
	assign wpres = ctrl_reg[`ORD_C_WPRES];
	assign impl  = ctrl_reg[`ORD_C_IMPLIED];

	////////////////////////////////////////////////////////////////
	// wishbone slave

	assign req = CYC_I & STB_I & ~ack_reg;

	// answer one cycle after the request, drop next cycle
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req;
		end
	end

	// writes land on the edge where the master sees ack
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			ctrl_reg <= `ORD_CTRL_RST;
			insn_reg <= `ORD_INSN_RST;
		end else if (CYC_I & STB_I & WE_I & ack_reg) begin
			// control: low byte and two bits of byte 1
			if (ADR_I == `ORD_ADR_CTRL) begin
				if (SEL_I[0]) begin
					ctrl_reg[7:0] <= DAT_I[7:0];
				end
				if (SEL_I[1]) begin
					ctrl_reg[9:8] <= DAT_I[9:8];
				end
			end
			// instruction bytes, per byte lane
			if (ADR_I == `ORD_ADR_INSN) begin
				for (int i = 0; i < 4; i++) begin
					if (SEL_I[i]) begin
						insn_reg[i*8 +: 8] <= DAT_I[i*8 +: 8];
					end
				end
			end
			// decode register and unmapped: write ignored
		end
	end

	// read mux; unused bits and unmapped words read zero
	always_comb begin
		rd_next = 32'h0000_0000;
		unique case (ADR_I)
			`ORD_ADR_CTRL: begin
				rd_next[`ORD_CTRL_W-1:0] = ctrl_reg;
			end
			`ORD_ADR_INSN: begin
				rd_next[24:0] = insn_reg[24:0];
			end
			`ORD_ADR_DEC: begin
				rd_next[29:0] = {noidx_reg, base_reg, index_reg,
					scale_reg, ext_reg, implied_reg, regmode_reg,
					stack_reg, disp_reg, sib_reg, seg_bad_reg,
					seg_reg, bytereg_reg, high_reg, gpr_reg,
					ad32_reg, size_reg};
			end
			default: begin
				rd_next = 32'h0000_0000;
			end
		endcase
	end

	// capture read data with the answer
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			dat_reg <= 32'h0000_0000;
		end else if (req & ~WE_I) begin
			dat_reg <= rd_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// size decode

	// legacy modes behave as default bit 0, prefixes toggle
	always_comb begin
		d_eff = ctrl_reg[`ORD_C_DBIT] & ~ctrl_reg[`ORD_C_LEGACY];
		op32  = d_eff ^ ctrl_reg[`ORD_C_OPFX];
		ad32  = d_eff ^ ctrl_reg[`ORD_C_APFX];
		if (wpres & ~wbit) begin
			size_next = ord_pkg::SZ8;
		end else if (op32) begin
			size_next = ord_pkg::SZ32;
		end else begin
			size_next = ord_pkg::SZ16;
		end
	end

	////////////////////////////////////////////////////////////////
	// register select

	// source field picked by instruction class
	always_comb begin
		unique case (ctrl_reg[`ORD_C_SRC_HI:`ORD_C_SRC_LO])
			`ORD_SRC_OPC: begin
				code = opc[2:0];
			end
			`ORD_SRC_MID: begin
				code = mid;
			end
			`ORD_SRC_RM: begin
				code = rmf;
			end
			default: begin
				// code 3 is illegal; fall back on opcode
				code = opc[2:0];
			end
		endcase
		// byte form: codes 4..7 are high halves of 0..3
		if (wpres & ~wbit) begin
			bytereg_next = 1'b1;
			high_next    = code[2];
			gpr_next     = {1'b0, code[1:0]};
		end else begin
			// word or dword form; width comes from size
			bytereg_next = 1'b0;
			high_next    = 1'b0;
			gpr_next     = code;
		end
		// middle bits as opcode extension when asked
		ext_next = ctrl_reg[`ORD_C_EXT] ? mid : 3'h0;
	end

	////////////////////////////////////////////////////////////////
	// segment select

	// two-bit field in opcode, three-bit in middle bits
	always_comb begin
		seg_bad_next = 1'b0;
		if (ctrl_reg[`ORD_C_SEG3]) begin
			if (mid[2:1] == 2'h3) begin
				seg_next     = ord_pkg::SEG_NONE;
				seg_bad_next = 1'b1;
			end else begin
				seg_next = ord_pkg::ord_seg_e'(mid);
			end
		end else begin
			seg_next = ord_pkg::ord_seg_e'({1'b0, opc[4:3]});
		end
	end

	////////////////////////////////////////////////////////////////
	// addressing mode

	// table chosen by address size; implied mode skips it
	always_comb begin
		regmode_next = (mdf == 2'h3) & ~impl;
		sib_next     = ad32 & (rmf == 3'h4)
			& (mdf != 2'h3) & ~impl;
		disp_next    = `ORD_DISP_NONE;
		stack_next   = 1'b0;
		if (impl | regmode_next) begin
			// fixed mode or register operand: no address
			disp_next  = `ORD_DISP_NONE;
			stack_next = 1'b0;
		end else if (~ad32) begin
			// 16-bit components
			unique case (mdf)
				2'h0: disp_next = (rmf == 3'h6) ? `ORD_DISP_16
					: `ORD_DISP_NONE;
				2'h1: disp_next = `ORD_DISP_8;
				default: disp_next = `ORD_DISP_16;
			endcase
			stack_next = (rmf[2:1] == 2'h1)
				| ((rmf == 3'h6) & (mdf != 2'h0));
		end else if (sib_next) begin
			// mode from mod and sib fields
			unique case (mdf)
				2'h0: disp_next = (basf == 3'h5) ? `ORD_DISP_32
					: `ORD_DISP_NONE;
				2'h1: disp_next = `ORD_DISP_8;
				default: disp_next = `ORD_DISP_32;
			endcase
			stack_next = (basf == 3'h4)
				| ((basf == 3'h5) & (mdf != 2'h0));
		end else begin
			// 32-bit components, no sib
			unique case (mdf)
				2'h0: disp_next = (rmf == 3'h5) ? `ORD_DISP_32
					: `ORD_DISP_NONE;
				2'h1: disp_next = `ORD_DISP_8;
				default: disp_next = `ORD_DISP_32;
			endcase
			stack_next = (rmf == 3'h5) & (mdf != 2'h0);
		end
	end

	////////////////////////////////////////////////////////////////
	// decode registers

	// one cycle behind the source registers; eases timing
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			size_reg    <= ord_pkg::SZ8;
			ad32_reg    <= 1'b0;
			gpr_reg     <= 3'h0;
			bytereg_reg <= 1'b0;
			high_reg    <= 1'b0;
			ext_reg     <= 3'h0;
		end else begin
			size_reg    <= size_next;
			ad32_reg    <= ad32;
			gpr_reg     <= gpr_next;
			bytereg_reg <= bytereg_next;
			high_reg    <= high_next;
			ext_reg     <= ext_next;
		end
	end

	// segment results
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			seg_reg     <= ord_pkg::SEG_EXTRA;
			seg_bad_reg <= 1'b0;
		end else begin
			seg_reg     <= seg_next;
			seg_bad_reg <= seg_bad_next;
		end
	end

	// address results; sib fields zero unless sib present
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			sib_reg     <= 1'b0;
			disp_reg    <= `ORD_DISP_NONE;
			stack_reg   <= 1'b0;
			regmode_reg <= 1'b0;
			implied_reg <= 1'b0;
			scale_reg   <= 2'h0;
			index_reg   <= 3'h0;
			base_reg    <= 3'h0;
			noidx_reg   <= 1'b0;
		end else begin
			sib_reg     <= sib_next;
			disp_reg    <= disp_next;
			stack_reg   <= stack_next;
			regmode_reg <= regmode_next;
			implied_reg <= impl;
			scale_reg   <= sib_next ? ssf : 2'h0;
			index_reg   <= sib_next ? idxf : 3'h0;
			base_reg    <= sib_next ? basf : 3'h0;
			noidx_reg   <= sib_next & (idxf == 3'h4);
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs

	assign DAT_O         = dat_reg;
	assign ACK_O         = ack_reg;
	assign OPSIZE_O      = size_reg;
	assign ADDR32_O      = ad32_reg;
	assign SIB_PRESENT_O = sib_reg;
	assign SEG_SEL_O     = seg_reg;
	assign SEG_BAD_O     = seg_bad_reg;

	////////////////////////////////////////////////////////////////
	// checks

	a_byte_width: assert property (
		@(posedge CLOCK_I) disable iff (RST_I)
		(wpres & ~wbit) |=> (size_reg == ord_pkg::SZ8))
		else $error("byte operand not 8 bits");

	// sampled reset keeps the release edge out: flops still load reset values there
	a_full_width: assert property (
		@(posedge CLOCK_I) disable iff (RST_I)
		~RST_I & ~(wpres & ~wbit) |=>
		(size_reg == ($past(op32) ? ord_pkg::SZ32 : ord_pkg::SZ16)))
		else $error("full operand width wrong");

	a_byte_high: assert property (
		@(posedge CLOCK_I) disable iff (RST_I)
		(wpres & ~wbit & code[2]) |=> (bytereg_reg & high_reg))
		else $error("high byte register not chosen");

	a_legacy_size: assert property (
		@(posedge CLOCK_I) disable iff (RST_I)
		(ctrl_reg[`ORD_C_LEGACY] & ~ctrl_reg[`ORD_C_APFX]) |=> ~ad32_reg)
		else $error("legacy mode not 16-bit address");

	a_prefix_flip: assert property (
		@(posedge CLOCK_I) disable iff (RST_I)
		$changed(ctrl_reg[`ORD_C_APFX]) & $stable(ctrl_reg[`ORD_C_DBIT])
		& $stable(ctrl_reg[`ORD_C_LEGACY]) |=> $changed(ad32_reg))
		else $error("address prefix did not toggle size");

	a_seg_unused: assert property (
		@(posedge CLOCK_I) disable iff (RST_I)
		(ctrl_reg[`ORD_C_SEG3] & (mid[2:1] == 2'h3)) |=>
		(seg_bad_reg & (seg_reg == ord_pkg::SEG_NONE)))
		else $error("unused segment code not flagged");

	a_seg_two: assert property (
		@(posedge CLOCK_I) disable iff (RST_I)
		~ctrl_reg[`ORD_C_SEG3] |=> (seg_reg[2] == 1'b0)
		& (seg_reg[1:0] == $past(opc[4:3])) & ~seg_bad_reg)
		else $error("two-bit segment out of range");

	a_sib_gate: assert property (
		@(posedge CLOCK_I) disable iff (RST_I)
		sib_reg |-> $past(ad32) & ($past(rmf) == 3'h4)
		& ($past(mdf) != 2'h3))
		else $error("sib flagged without its conditions");

	a_implied_mode: assert property (
		@(posedge CLOCK_I) disable iff (RST_I)
		impl |=> ~sib_reg & (disp_reg == `ORD_DISP_NONE) & ~regmode_reg)
		else $error("implied mode used addressing bytes");

	a_ack_pulse: assert property (
		@(posedge CLOCK_I) disable iff (RST_I)
		(CYC_I & STB_I & ~ACK_O) |=> ACK_O ##1 ~ACK_O)
		else $error("bus answer not a one-cycle pulse");

endmodule

// ### hdl/ord_map.svh
`ifndef ORD_MAP_SVH
`define ORD_MAP_SVH

// register byte offsets on the bus
`define ORD_ADR_CTRL    8'h00
`define ORD_ADR_INSN    8'h04
`define ORD_ADR_DEC     8'h08

// control register width and reset value
`define ORD_CTRL_W      10
`define ORD_CTRL_RST    10'h000

// control register bit positions
`define ORD_C_DBIT      0
`define ORD_C_LEGACY    1
`define ORD_C_WPRES     2
`define ORD_C_IMPLIED   3
`define ORD_C_EXT       4
`define ORD_C_SRC_LO    5
`define ORD_C_SRC_HI    6
`define ORD_C_OPFX      7
`define ORD_C_APFX      8
`define ORD_C_SEG3      9

// instruction register layout and reset
`define ORD_INSN_RST    32'h0000_0000
`define ORD_I_WBIT      24

// register source codes
`define ORD_SRC_OPC     2'h0
`define ORD_SRC_MID     2'h1
`define ORD_SRC_RM      2'h2

// displacement size codes
`define ORD_DISP_NONE   2'h0
`define ORD_DISP_8      2'h1
`define ORD_DISP_16     2'h2
`define ORD_DISP_32     2'h3

`endif

// ### hdl/ord_pkg.sv
package ord_pkg;

	// operand width after decode
	typedef enum logic [1:0] {
		SZ8,
		SZ16,
		SZ32
	} ord_size_e;

	// segment picked; order follows the field codes
	typedef enum logic [2:0] {
		SEG_EXTRA,
		SEG_CODE,
		SEG_STACK,
		SEG_DATA,
		SEG_F,
		SEG_G,
		SEG_NONE
	} ord_seg_e;

endpackage

// ### testbench/ord_fetch_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
// prefetch side: classic single-cycle bus master
module ord_fetch_model (
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic      [7:0]  adr_o,
	output logic      [3:0]  sel_o,
	output logic      [31:0] dat_o
);
	// idle bus from time zero
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o  = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end

	// request held until ack is sampled or 16 edges pass; no fixed latency assumed
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q, output bit ok);
		int k;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o  <= w;
		adr_o <= a;
		sel_o <= s;
		dat_o <= d;
		ok = 1'b0;
		for (k = 0; k < 16 && !ok; k++) begin
			@(posedge clk_i);
			ok = (ack_i === 1'b1);
		end
		q = dat_i;
		// released lines flip so a stale value is never trusted
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o  <= 1'b0;
		adr_o <= ~a;
		sel_o <= ~s;
		dat_o <= ~d;
	endtask
endmodule

// ### testbench/test_ord_decode.sv
`timescale 1ns/1ns
`include "ord_map.svh"
module test_ord_decode;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc, stb, we, ack, a32, sib, sbad;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, msk, q1, q2;
	logic [1:0]  ops;
	logic [2:0]  seg;
	int          n_mismatch = 0;
	int          compares = 0;

	ord_decode ord_decode_inst (.CLOCK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb),
		.WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
		.OPSIZE_O(ops), .ADDR32_O(a32), .SIB_PRESENT_O(sib), .SEG_SEL_O(seg),
		.SEG_BAD_O(sbad));
	ord_fetch_model ord_fetch_model_inst (.clk_i(clk), .ack_i(ack), .dat_i(rdat),
		.cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

	// 25 MHz
	always #20 clk = ~clk;

	////////////////////////////////////////////////////////////
	// verdict, reached from the end or from a hung bus
	task close_out;
		if (n_mismatch == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// bus access; a lost ack ends the run
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		bit ok;
		ord_fetch_model_inst.xfer(w, a, d, s, q, ok);
		if (!ok) begin
			n_mismatch++;
			close_out();
		end
	endtask

	task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, 4'h0, q);
		cmp(nm, e, q);
	endtask

	////////////////////////////////////////////////////////////
	// reference decode; msk drops fields left open
	function automatic logic [31:0] model(input logic [9:0] c, input logic [31:0] i);
		logic       d, o32, ad, byt, imp, sb;
		logic [2:0] cd, md, rm;
		logic [1:0] mo;
		logic [31:0] r;
		d = c[0] & ~c[1];
		o32 = d ^ c[7];
		ad = d ^ c[8];
		byt = c[2] & ~i[24];
		imp = c[3];
		mo = i[15:14];
		md = i[13:11];
		rm = i[10:8];
		cd = (c[6:5] == 2'h1) ? md : (c[6:5] == 2'h2) ? rm : i[2:0];
		sb = ad & (rm == 3'h4) & (mo != 2'h3) & ~imp;
		r = 32'h0;
		r[1:0] = byt ? 2'h0 : o32 ? 2'h2 : 2'h1;
		r[2] = ad;
		r[5:3] = byt ? {1'b0, cd[1:0]} : cd;
		r[6] = byt & cd[2];
		r[7] = byt;
		r[10:8] = c[9] ? (md > 3'h5 ? 3'h6 : md) : {1'b0, i[4:3]};
		r[11] = c[9] & (md > 3'h5);
		r[12] = sb;
		case (mo)
			2'h0: r[14:13] = ad ? (rm == 3'h5 ? 2'h3 : 2'h0) : (rm == 3'h6 ? 2'h2 : 2'h0);
			2'h1: r[14:13] = 2'h1;
			2'h2: r[14:13] = ad ? 2'h3 : 2'h2;
			default: r[14:13] = 2'h0;
		endcase
		// stack segment by default for bp-based forms
		r[15] = (mo != 2'h3) & (ad ? (rm == 3'h5) & (mo != 2'h0)
			: (rm[2:1] == 2'h1) | ((rm == 3'h6) & (mo != 2'h0)));
		r[16] = (mo == 2'h3);
		// implied mode: no displacement, no stack default, no register form
		if (imp)
			r[16:13] = 4'h0;
		r[17] = imp;
		r[20:18] = c[4] ? md : 3'h0;
		if (sb)
			r[29:21] = {i[21:19] == 3'h4, i[18:16], i[21:19], i[23:22]};
		// sib addressing table is left open: mask its displacement and stack bits
		msk = 32'h3fff_ffff;
		if (sb)
			msk[15:13] = 3'h0;
		return r;
	endfunction

	// load both registers, then check pins and decode word
	task run(input logic [9:0] c, input logic [31:0] i);
		logic [31:0] r, q;
		r = model(c, i);
		bus(1'b1, `ORD_ADR_CTRL, {22'h0, c}, 4'hf, q);
		bus(1'b1, `ORD_ADR_INSN, i, 4'hf, q);
		repeat (2) @(posedge clk);
		#1;
		cmp("pins", {24'h0, r[12:8], r[2:0]}, {24'h0, sib, sbad, seg, a32, ops});
		bus(1'b0, `ORD_ADR_DEC, 32'h0, 4'h0, q);
		cmp("dec", r & msk, q & msk);
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		cmp("pins in reset", 32'h0, {24'h0, sib, sbad, seg, a32, ops});
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		cmp("pins after reset", 32'h1, {24'h0, sib, sbad, seg, a32, ops});
		rdc("ctrl", `ORD_ADR_CTRL, 32'h0);
		rdc("insn", `ORD_ADR_INSN, 32'h0);
		rdc("unmapped", 8'h0c, 32'h0);
		// lanes: full write, no lanes, lane 0 only
		bus(1'b1, `ORD_ADR_CTRL, 32'hffff_ffff, 4'hf, q1);
		rdc("ctrl", `ORD_ADR_CTRL, 32'h3ff);
		bus(1'b1, `ORD_ADR_CTRL, 32'h0, 4'h0, q1);
		rdc("ctrl", `ORD_ADR_CTRL, 32'h3ff);
		bus(1'b1, `ORD_ADR_CTRL, 32'h0, 4'h1, q1);
		rdc("ctrl", `ORD_ADR_CTRL, 32'h300);
		bus(1'b1, `ORD_ADR_INSN, 32'hffff_ffff, 4'hf, q1);
		rdc("insn", `ORD_ADR_INSN, 32'h01ff_ffff);
		// decode word is read only; unmapped writes vanish
		bus(1'b0, `ORD_ADR_DEC, 32'h0, 4'h0, q1);
		bus(1'b1, `ORD_ADR_DEC, ~q1, 4'hf, q2);
		bus(1'b1, 8'h0c, 32'hffff_ffff, 4'hf, q2);
		rdc("dec", `ORD_ADR_DEC, q1);
		rdc("unmapped", 8'h0c, 32'h0);
		// sizes, prefixes, legacy mode and register picks from all sources
		for (int n = 0; n < 256; n++)
			run({1'b0, n[4], n[3], n[6:5], 2'h0, n[2:0]},
				{7'h0, n[7], 8'h0, 2'h3, n[2:0] ^ 3'h5, n[4:2], 5'h0, n[5:3]});
		// both segment fields, opcode extension; 110 and 111 sent on purpose
		for (int n = 0; n < 32; n++)
			run({n[4], 4'h0, n[3], 4'h0}, {18'h0, n[2:0], 3'h0, 3'h0, n[1:0], 3'h0});
		// every mod and rm under both address sizes, with and without implied mode
		for (int n = 0; n < 128; n++)
			run({1'b0, 5'h0, n[6], 2'h0, n[5]},
				{8'h0, n[1:0], n[4:2] ^ 3'h1, n[6:4], n[4:3], 3'h2, n[2:0], 8'h0});
		// address prefix alone flips address size both ways
		run(10'h101, 32'h0000_0400);
		run(10'h001, 32'h0000_0400);
		close_out();
	end
endmodule
